// [core/ebsc_consts.svh]
// offsets, field positions and timing counts for the endpoint buffer controller
`ifndef EBSC_CONSTS_SVH
`define EBSC_CONSTS_SVH

// ==========================================
// device register offsets
`define EBSC_OFS_DATA_PORT 8'h20
`define EBSC_OFS_BUF_CMD 8'h28
`define EBSC_OFS_TARGET_SEL 8'h2c

// ==========================================
// target select fields
`define EBSC_SEL_DIR_BIT 0
`define EBSC_SEL_EP_LSB 1
`define EBSC_SEL_SETUP_BIT 5
`define EBSC_SEL_RESET 8'h20

// ==========================================
// buffer command fields
`define EBSC_CMD_STALL_BIT 0
`define EBSC_CMD_STATUS_BIT 1
`define EBSC_CMD_PERMIT_BIT 2
`define EBSC_CMD_COMMIT_BIT 3
`define EBSC_CMD_FLUSH_BIT 4
`define EBSC_CMD_USED_MASK 8'h1f

// ==========================================
// timing
`define EBSC_CLK_NS 40
`define EBSC_RD_GAP_NS 190
`define EBSC_WR_GAP_NS 100
`define EBSC_RD_GAP_CYC ((`EBSC_RD_GAP_NS + `EBSC_CLK_NS - 1) / `EBSC_CLK_NS)
`define EBSC_WR_GAP_CYC ((`EBSC_WR_GAP_NS + `EBSC_CLK_NS - 1) / `EBSC_CLK_NS)

`endif

// [core/ebsc_ctrl.sv]
// endpoint buffer controller: drives the device's select and command registers
// Function
// - clear setup select for other buffers
// - fixed encoding of setup, control, data buffers
// - select never equals the DMA endpoint
// - wait 190 ns before reading data port
// - wait 100 ns before writing data port
// - write select before touching command register
// - flush twice for double buffered endpoint
// - OUT data stage only after permit (not enforced here: data port reads go out with no check for a prior permit)
// - permit before filling control IN FIFO (not enforced here: data port writes go out with no check for a prior permit)
// - status acknowledge allowed without data stage
`include "ebsc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module ebsc_ctrl #(
    parameter int STROBE_CYC = 2,
    parameter int EP_COUNT = 16
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    // user side
    input wire logic i_cmd_valid,
    input wire ebsc_pkg::ebsc_op_t i_cmd_op,
    input wire ebsc_pkg::ebsc_buf_t i_cmd_buf,
    input wire logic [3:0] i_cmd_ep,
    input wire logic i_cmd_dir,
    input wire logic i_cmd_double,
    input wire logic [15:0] i_cmd_data,
    input wire logic [3:0] i_dma_ep,
    output logic o_cmd_ready,
    output logic o_rsp_valid,
    output logic o_rsp_err,
    output logic [15:0] o_rsp_data,
    // device side
    output logic [7:0] o_dev_addr,
    output logic o_dev_cs_n,
    output logic o_dev_rd_n,
    output logic o_dev_wr_n,
    input wire logic [15:0] i_dev_data,
    output logic [15:0] o_dev_data,
    output logic o_dev_data_oe_n
);
    import ebsc_pkg::*;

    // ==========================================
    // elaboration checks
    generate
        if (STROBE_CYC < 1 || STROBE_CYC > 250) begin : g_bad_strobe
            $error("STROBE_CYC must be 1 to 250");
        end
        if (EP_COUNT < 1 || EP_COUNT > 16) begin : g_bad_ep
            $error("EP_COUNT must be 1 to 16");
        end
    endgenerate

    localparam logic [7:0] LAST_PH = 8'(STROBE_CYC + 1);

    typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_GAP, ST_OP, ST_RSP} ebsc_state_t;

    ebsc_state_t state;
    logic [7:0] ph;
    logic again;
    ebsc_op_t op;
    logic [7:0] sel_val;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic err;

    ebsc_gap_if gap ();

    ebsc_gap_timer u_gap (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .gap(gap)
    );

    // ==========================================
    // helpers
    function automatic logic [7:0] sel_encode(input ebsc_buf_t b, input logic [3:0] ep,
                                              input logic dir);
        logic [7:0] v;
        v = 8'h00;
        unique case (b)
            EBSC_BUF_SETUP: v[`EBSC_SEL_SETUP_BIT] = 1'b1;
            EBSC_BUF_CTRL: v[`EBSC_SEL_DIR_BIT] = dir;
            EBSC_BUF_DATA: begin
                // setup select stays 0 for every other buffer
                v[`EBSC_SEL_EP_LSB +: 4] = ep;
                v[`EBSC_SEL_DIR_BIT] = dir;
            end
        endcase
        return v;
    endfunction

    function automatic logic [7:0] cmd_encode(input ebsc_op_t o, input logic stall);
        logic [7:0] v;
        v = 8'h00;
        unique case (o)
            EBSC_OP_FLUSH: v[`EBSC_CMD_FLUSH_BIT] = 1'b1;
            EBSC_OP_COMMIT: v[`EBSC_CMD_COMMIT_BIT] = 1'b1;
            EBSC_OP_PERMIT: v[`EBSC_CMD_PERMIT_BIT] = 1'b1;
            EBSC_OP_STATUS: v[`EBSC_CMD_STATUS_BIT] = 1'b1;
            EBSC_OP_STALL: v[`EBSC_CMD_STALL_BIT] = stall;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic [3:0] sel_ep(input ebsc_buf_t b, input logic [3:0] ep);
        return (b == EBSC_BUF_DATA) ? ep : 4'h0;
    endfunction

    // ==========================================
    // sequencer
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            ph <= 8'h00;
            again <= 1'b0;
            op <= EBSC_OP_SELECT;
            sel_val <= `EBSC_SEL_RESET;
            wdata <= 16'h0000;
            err <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (i_cmd_valid) begin
                        op <= i_cmd_op;
                        sel_val <= sel_encode(i_cmd_buf, i_cmd_ep, i_cmd_dir);
                        ph <= 8'h00;
                        // a double-buffered flush is issued twice
                        again <= (i_cmd_op == EBSC_OP_FLUSH) && i_cmd_double;
                        if (i_cmd_op == EBSC_OP_WR_DATA) begin
                            wdata <= i_cmd_data;
                        end else begin
                            wdata <= {8'h00, cmd_encode(i_cmd_op, i_cmd_data[0])};
                        end
                        // refuse a select that would alias the DMA endpoint
                        if (sel_ep(i_cmd_buf, i_cmd_ep) == i_dma_ep
                                || 32'(sel_ep(i_cmd_buf, i_cmd_ep)) >= EP_COUNT) begin
                            err <= 1'b1;
                            state <= ST_RSP;
                        end else begin
                            err <= 1'b0;
                            state <= ST_SEL; // select always precedes the access
                        end
                    end
                end
                ST_SEL: begin
                    if (ph == LAST_PH) begin
                        ph <= 8'h00;
                        state <= (op == EBSC_OP_SELECT) ? ST_RSP : ST_GAP;
                    end else begin
                        ph <= ph + 8'h01;
                    end
                end
                ST_GAP: begin
                    if (gap.done) begin
                        state <= ST_OP;
                    end
                end
                ST_OP: begin
                    if (ph == LAST_PH) begin
                        ph <= 8'h00;
                        if (again) begin
                            again <= 1'b0;
                        end else begin
                            state <= ST_RSP;
                        end
                    end else begin
                        ph <= ph + 8'h01;
                    end
                end
                ST_RSP: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // gap timer start, on the cycle the select strobe ends
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            gap.start <= 1'b0;
            gap.count <= 8'h00;
        end else begin
            gap.start <= (state == ST_SEL) && (ph == LAST_PH) && (op != EBSC_OP_SELECT);
            if (op == EBSC_OP_RD_DATA || op == EBSC_OP_RD_CMD) begin
                gap.count <= 8'(`EBSC_RD_GAP_CYC);
            end else begin
                gap.count <= 8'(`EBSC_WR_GAP_CYC);
            end
        end
    end

    // ==========================================
    // device pins
    // strobes trail state by one cycle; ph 0 is address setup, last ph is recovery
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_dev_addr <= 8'h00;
            o_dev_cs_n <= 1'b1;
            o_dev_rd_n <= 1'b1;
            o_dev_wr_n <= 1'b1;
            o_dev_data <= 16'h0000;
            o_dev_data_oe_n <= 1'b1;
        end else begin
            if (state == ST_SEL) begin
                o_dev_addr <= `EBSC_OFS_TARGET_SEL;
                o_dev_data <= {8'h00, sel_val};
            end else if (state == ST_OP) begin
                o_dev_addr <= (op == EBSC_OP_RD_DATA || op == EBSC_OP_WR_DATA) ?
                              `EBSC_OFS_DATA_PORT : `EBSC_OFS_BUF_CMD;
                o_dev_data <= wdata;
            end
            o_dev_cs_n <= !((state == ST_SEL || state == ST_OP) && ph != LAST_PH);
            o_dev_wr_n <= !((state == ST_SEL
                             || (state == ST_OP && op != EBSC_OP_RD_DATA && op != EBSC_OP_RD_CMD))
                            && ph != 8'h00 && ph != LAST_PH);
            o_dev_rd_n <= !(state == ST_OP && (op == EBSC_OP_RD_DATA || op == EBSC_OP_RD_CMD)
                            && ph != 8'h00 && ph != LAST_PH);
            o_dev_data_oe_n <= !((state == ST_SEL
                                  || (state == ST_OP && op != EBSC_OP_RD_DATA
                                      && op != EBSC_OP_RD_CMD))
                                 && ph != LAST_PH);
        end
    end

    // ==========================================
    // read capture and response
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            rdata <= 16'h0000;
        end else if (state == ST_OP && ph == LAST_PH && op == EBSC_OP_RD_CMD) begin
            // permit bit is write only; never trust what the pins show for it
            rdata <= {8'h00, i_dev_data[7:0] & `EBSC_CMD_USED_MASK
                      & ~(8'h01 << `EBSC_CMD_PERMIT_BIT)};
        end else if (state == ST_OP && ph == LAST_PH && op == EBSC_OP_RD_DATA) begin
            // each read advances the device's own pointer; a full read empties it
            rdata <= i_dev_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_cmd_ready <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_err <= 1'b0;
            o_rsp_data <= 16'h0000;
        end else begin
            o_cmd_ready <= (state == ST_IDLE) && !i_cmd_valid;
            o_rsp_valid <= (state == ST_RSP);
            if (state == ST_RSP) begin
                o_rsp_err <= err;
                o_rsp_data <= err ? 16'h0000 : rdata;
            end
        end
    end
endmodule

`default_nettype wire

// [core/ebsc_gap_if.sv]
// carrier between the sequencer and its gap timer
`timescale 1ns/1ns
`default_nettype none

interface ebsc_gap_if;
    logic start;
    logic [7:0] count;
    logic done;

    modport ctl (output start, output count, input done);
    modport tmr (input start, input count, output done);
endinterface

`default_nettype wire

// [core/ebsc_gap_timer.sv]
// gap timer: counts the settle time after a target select write
`timescale 1ns/1ns
`default_nettype none

module ebsc_gap_timer (
    input wire logic i_clock,
    input wire logic i_nrst,
    ebsc_gap_if.tmr gap
);
    logic [7:0] remain;
    logic running;

    // ==========================================
    // countdown
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            remain <= 8'h00;
            running <= 1'b0;
            gap.done <= 1'b0;
        end else if (gap.start) begin
            remain <= gap.count;
            running <= 1'b1;
            gap.done <= 1'b0;
        end else if (running) begin
            // done one cycle after the count runs out, so the gap is never short
            if (remain <= 8'h01) begin
                running <= 1'b0;
                gap.done <= 1'b1;
            end else begin
                remain <= remain - 8'h01;
                gap.done <= 1'b0;
            end
        end else begin
            gap.done <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// [core/ebsc_pkg.sv]
// types shared by the endpoint buffer controller
package ebsc_pkg;

    typedef enum logic [3:0] {
        EBSC_OP_SELECT,
        EBSC_OP_FLUSH,
        EBSC_OP_COMMIT,
        EBSC_OP_PERMIT,
        EBSC_OP_STATUS,
        EBSC_OP_STALL,
        EBSC_OP_RD_DATA,
        EBSC_OP_WR_DATA,
        EBSC_OP_RD_CMD
    } ebsc_op_t;

    typedef enum logic [1:0] {
        EBSC_BUF_SETUP,
        EBSC_BUF_CTRL,
        EBSC_BUF_DATA
    } ebsc_buf_t;

endpackage

// [testbench/ebsc_ctrl_props.sv]
// pin-level checker for the endpoint buffer controller
`timescale 1ns/1ns
`default_nettype none
module ebsc_ctrl_props #(
    parameter int STROBE_CYC = 2,
    parameter int EP_COUNT = 16
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [3:0] i_dma_ep,
    input wire logic o_rsp_valid,
    input wire logic o_rsp_err,
    input wire logic [7:0] o_dev_addr,
    input wire logic o_dev_cs_n,
    input wire logic o_dev_rd_n,
    input wire logic o_dev_wr_n,
    input wire logic [15:0] o_dev_data,
    input wire logic o_dev_data_oe_n
);
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // ==========================================
    // helpers: cycles since a select write ended
    logic sel_wr;
    logic sel_seen;
    logic [7:0] gap;
    assign sel_wr = !o_dev_wr_n && o_dev_addr == 8'h2c;
    always_ff @(posedge i_clock) begin
        if (!i_nrst || sel_wr) begin
            gap <= 8'h00;
        end else if (gap != 8'hff) begin
            gap <= gap + 8'h01;
        end
    end
    always_ff @(posedge i_clock) begin
        if (!i_nrst || o_rsp_valid) begin
            sel_seen <= 1'b0;
        end else if (sel_wr) begin
            sel_seen <= 1'b1;
        end
    end
    // ==========================================
    // properties
    sequence wr_pulse;
        !o_dev_wr_n [*2] ##1 o_dev_wr_n;
    endsequence
    sequence rd_start;
        $fell(o_dev_rd_n) && o_dev_addr == 8'h20;
    endsequence
    sel_rsvd_a: assert property (sel_wr |-> o_dev_data[7:6] == 2'b00)
        else $error("reserved select bits written");
    setup_only_a: assert property (sel_wr && o_dev_data[5]
        |-> o_dev_data[4:0] == 5'h00)
        else $error("setup select with other buffer");
    dma_apart_a: assert property (sel_wr |-> o_dev_data[4:1] != i_dma_ep)
        else $error("select equals dma endpoint");
    rd_gap_a: assert property (rd_start |-> gap >= 8'h05)
        else $error("data read too soon after select");
    wr_gap_a: assert property ($fell(o_dev_wr_n) && o_dev_addr == 8'h20 |-> gap >= 8'h03)
        else $error("data write too soon after select");
    sel_first_a: assert property ($fell(o_dev_cs_n) && o_dev_addr == 8'h28 |-> sel_seen)
        else $error("command access without select");
    refuse_quiet_a: assert property (o_rsp_valid && o_rsp_err |->
        $past(o_dev_cs_n) && $past(o_dev_cs_n, 2))
        else $error("pins moved on refused command");
    wr_shape_a: assert property ($fell(o_dev_wr_n) |-> wr_pulse)
        else $error("write strobe of wrong length");
    rd_free_a: assert property (!o_dev_rd_n |-> o_dev_data_oe_n && !o_dev_cs_n)
        else $error("bus driven during read");
endmodule
bind ebsc_ctrl ebsc_ctrl_props #(.STROBE_CYC(STROBE_CYC), .EP_COUNT(EP_COUNT)) u_props (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_dma_ep(i_dma_ep), .o_rsp_valid(o_rsp_valid),
    .o_rsp_err(o_rsp_err), .o_dev_addr(o_dev_addr), .o_dev_cs_n(o_dev_cs_n),
    .o_dev_rd_n(o_dev_rd_n), .o_dev_wr_n(o_dev_wr_n), .o_dev_data(o_dev_data),
    .o_dev_data_oe_n(o_dev_data_oe_n));
`default_nettype wire

// [testbench/ebsc_dev_model.sv]
// behavioural model of the device's select and command registers
`timescale 1ns/1ns
`default_nettype none
module ebsc_dev_model #(
    parameter int MAX_PKT = 4
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_bus_reset,
    input wire logic i_token_ack,
    input wire logic [7:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data
);
    logic [7:0] sel;
    logic stall, status, permit, rd_q, wr_q;
    logic [7:0] cnt [0:32];
    logic rdy [0:32];
    logic [7:0] flushes;
    logic [15:0] last, val;
    logic [5:0] idx;
    assign idx = sel[5] ? 6'h20 : {1'b0, sel[4:0]};
    always_comb begin
        case (i_addr)
            8'h2c: val = {8'h00, sel};
            8'h28: val = {14'h0000, status, stall};
            default: val = {2'b00, idx, cnt[idx]};
        endcase
    end
    // released bus shows the inverse so a stale sample cannot pass
    assign o_data = (!i_cs_n && !i_rd_n) ? val : ~last;
    always @(posedge i_clock) begin
        rd_q <= !i_cs_n && !i_rd_n && i_addr == 8'h20;
        wr_q <= !i_cs_n && !i_wr_n;
        if (!i_cs_n && !i_rd_n) last <= val;
        if (!i_nrst) begin
            sel <= 8'h20;
            {stall, status, permit} <= 3'b000;
            flushes <= 8'h00;
            for (int k = 0; k < 33; k++) begin
                cnt[k] <= 8'h00;
                rdy[k] <= 1'b0;
            end
        end else if (i_bus_reset) begin
            sel[4:0] <= 5'h00;
            {stall, status, permit} <= 3'b000;
        end else if (!wr_q && !i_cs_n && !i_wr_n) begin
            case (i_addr)
                8'h2c: sel <= {2'b00, i_data[5:0]};
                8'h28: begin
                    stall <= i_data[0];
                    status <= i_data[1];
                    permit <= i_data[2];
                    if (i_data[4]) begin
                        cnt[idx] <= 8'h00;
                        rdy[idx] <= 1'b0;
                        flushes <= flushes + 8'h01;
                    end
                    if (i_data[3]) rdy[idx] <= 1'b1;
                end
                default: if (sel[0]) begin
                    cnt[idx] <= cnt[idx] + 8'h01;
                    if (cnt[idx] == 8'(MAX_PKT - 1)) rdy[idx] <= 1'b1;
                end
            endcase
        end else if (rd_q && !(!i_cs_n && !i_rd_n) && cnt[idx] != 8'h00) begin
            cnt[idx] <= cnt[idx] - 8'h01;
        end
        if (i_token_ack) permit <= 1'b0;
    end
    task automatic host_out(input logic [5:0] k, input logic [7:0] n);
        cnt[k] = n;
    endtask
endmodule
`default_nettype wire

// [testbench/tb_ebsc_ctrl.sv]
// self-checking bench for the endpoint buffer controller
`timescale 1ns/1ns
`default_nettype none
module tb_ebsc_ctrl;
    import ebsc_pkg::*;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic cmd_valid = 1'b0;
    ebsc_op_t cmd_op = EBSC_OP_SELECT;
    ebsc_buf_t cmd_buf = EBSC_BUF_SETUP;
    logic [3:0] cmd_ep = 4'h0;
    logic [3:0] dma_ep = 4'hf;
    logic cmd_dir = 1'b0;
    logic cmd_double = 1'b0;
    logic token_ack = 1'b0;
    logic [15:0] cmd_data = 16'h0000;
    logic cmd_ready, rsp_valid, rsp_err, cs_n, rd_n, wr_n, oe_n;
    logic [15:0] rsp_data, dev_rd, dev_wr;
    logic [7:0] dev_addr;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    ebsc_ctrl uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_cmd_valid(cmd_valid),
        .i_cmd_op(cmd_op), .i_cmd_buf(cmd_buf), .i_cmd_ep(cmd_ep), .i_cmd_dir(cmd_dir),
        .i_cmd_double(cmd_double), .i_cmd_data(cmd_data), .i_dma_ep(dma_ep),
        .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_err(rsp_err),
        .o_rsp_data(rsp_data), .o_dev_addr(dev_addr), .o_dev_cs_n(cs_n), .o_dev_rd_n(rd_n),
        .o_dev_wr_n(wr_n), .i_dev_data(dev_rd), .o_dev_data(dev_wr), .o_dev_data_oe_n(oe_n));
    ebsc_dev_model dev (.i_clock(i_clock), .i_nrst(i_nrst), .i_bus_reset(1'b0),
        .i_token_ack(token_ack), .i_addr(dev_addr), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_data(dev_wr), .o_data(dev_rd));
    always #20 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ==========================================
    // shared tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic op(input ebsc_op_t o, input ebsc_buf_t b, input logic [3:0] e,
        input logic d, input logic [15:0] w, input logic xe);
        @(negedge i_clock);
        chk("ready idle", {15'h0000, cmd_ready}, 16'h0001);
        cmd_op = o;
        cmd_buf = b;
        cmd_ep = e;
        cmd_dir = d;
        cmd_data = w;
        cmd_valid = 1'b1;
        for (int k = 0; k < 200 && rsp_valid !== 1'b1; k++) @(negedge i_clock);
        chk("response", {15'h0000, rsp_valid}, 16'h0001);
        chk("ready busy", {15'h0000, cmd_ready}, 16'h0000);
        chk("error flag", {15'h0000, rsp_err}, {15'h0000, xe});
        cmd_valid = 1'b0;
    endtask
    // ==========================================
    // scenarios
    task automatic t_select;
        ebsc_buf_t bl [5] = '{EBSC_BUF_CTRL, EBSC_BUF_SETUP, EBSC_BUF_CTRL, EBSC_BUF_DATA,
            EBSC_BUF_DATA};
        logic [4:0] ed [5] = '{5'h00, 5'h00, 5'h01, 5'h0b, 5'h1c};
        for (int i = 0; i < 5; i++) begin
            op(EBSC_OP_SELECT, bl[i], ed[i][4:1], ed[i][0], 16'h0000, 1'b0);
            chk("select", {8'h00, dev.sel}, (i == 1) ? 16'h0020 : {11'h000, ed[i]});
        end
    endtask
    task automatic t_refuse;
        dma_ep = 4'h5;
        op(EBSC_OP_SELECT, EBSC_BUF_DATA, 4'h5, 1'b1, 16'h0000, 1'b1);
        chk("select kept", {8'h00, dev.sel}, 16'h001c);
        dma_ep = 4'h0;
        op(EBSC_OP_FLUSH, EBSC_BUF_CTRL, 4'h0, 1'b0, 16'h0000, 1'b1);
        dma_ep = 4'hf;
    endtask
    task automatic t_data;
        dev.host_out(6'h04, 8'h02);
        op(EBSC_OP_RD_DATA, EBSC_BUF_DATA, 4'h2, 1'b0, 16'h0000, 1'b0);
        chk("read one", rsp_data, 16'h0402);
        op(EBSC_OP_RD_DATA, EBSC_BUF_DATA, 4'h2, 1'b0, 16'h0000, 1'b0);
        chk("read two", rsp_data, 16'h0401);
        for (int i = 0; i < 3; i++) op(EBSC_OP_WR_DATA, EBSC_BUF_DATA, 4'h3, 1'b1, 16'h1234, 1'b0);
        chk("tx count", {8'h00, dev.cnt[7]}, 16'h0003);
        op(EBSC_OP_COMMIT, EBSC_BUF_DATA, 4'h3, 1'b1, 16'h0000, 1'b0);
        chk("committed", {15'h0000, dev.rdy[7]}, 16'h0001);
    endtask
    task automatic t_flush;
        dev.host_out(6'h06, 8'h05);
        cmd_double = 1'b1;
        op(EBSC_OP_FLUSH, EBSC_BUF_DATA, 4'h3, 1'b0, 16'h0000, 1'b0);
        cmd_double = 1'b0;
        chk("flush count", {8'h00, dev.flushes}, 16'h0002);
        chk("rx flushed", {8'h00, dev.cnt[6]}, 16'h0000);
    endtask
    task automatic t_cmd;
        ebsc_op_t ol [3] = '{EBSC_OP_STATUS, EBSC_OP_STALL, EBSC_OP_PERMIT};
        logic [15:0] xl [3] = '{16'h0002, 16'h0001, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            op(ol[i], EBSC_BUF_CTRL, 4'h0, 1'b1, 16'h0001, 1'b0);
            op(EBSC_OP_RD_CMD, EBSC_BUF_CTRL, 4'h0, 1'b1, 16'h0000, 1'b0);
            chk("command read", rsp_data, xl[i]);
        end
        chk("permit set", {15'h0000, dev.permit}, 16'h0001);
        @(negedge i_clock);
        token_ack = 1'b1;
        @(negedge i_clock);
        token_ack = 1'b0;
        chk("permit cleared", {15'h0000, dev.permit}, 16'h0000);
    endtask
    task automatic finish_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
        i_nrst = 1'b1;
        t_select();
        t_refuse();
        t_data();
        t_flush();
        t_cmd();
        finish_test();
    end
endmodule
`default_nettype wire
